// ---- core/ppr_defs.svh ----
// register map, field positions and reset values of the parallel port block
`ifndef PPR_DEFS_SVH
`define PPR_DEFS_SVH

// register indices; byte address is four times the index
`define PPR_IDX_DATA 3'h0
`define PPR_IDX_STATUS 3'h1
`define PPR_IDX_CONTROL 3'h2
`define PPR_IDX_EVT_STATUS 3'h3
`define PPR_IDX_EVT_MASK 3'h4

// port control register fields
`define PPR_CTL_STROBE 0
`define PPR_CTL_AUTOFEED 1
`define PPR_CTL_INIT 2
`define PPR_CTL_SELECT 3
`define PPR_CTL_IRQ_EN 4
`define PPR_CTL_DIR 5
`define PPR_CTL_WMASK 8'h3F

// port status register fields
`define PPR_STS_FIXED 2'h3
`define PPR_STS_FLAG 2

// event status and mask register fields
`define PPR_EVT_RELEASE 0
`define PPR_EVT_FAULT 1
`define PPR_EVT_MEDIA 2
`define PPR_EVT_W 3

// reset values
`define PPR_DATA_RST 8'h00
`define PPR_CTL_RST 8'h00
`define PPR_EVT_RST 3'h0
`define PPR_IN_RST 5'h1F

`endif

// ---- core/ppr_pkg.sv ----
// types shared by the parallel port block
package ppr_pkg;
  // one byte of the parallel data lines or a port register
  typedef logic [7:0] ppr_byte_t;
  // bus read data word
  typedef logic [31:0] ppr_word_t;
endpackage

// ---- core/ppr_sync.sv ----
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module ppr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);
  logic [W-1:0] meta_reg; // first stage, read only by second stage

  // ---------------------------------------------------------------
  // two stages, both reset to a constant
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_reg <= RST_VAL;
      level_out <= RST_VAL;
    end else begin
      meta_reg <= pin_in;
      level_out <= meta_reg;
    end
  end
endmodule // ppr_sync
`default_nettype wire

// ---- core/ppr_port.sv ----
// parallel printer port registers with apb slave and pin logic
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "ppr_defs.svh"
module ppr_port #(
  parameter int ADDR_W = 5
) (
  input wire logic clock,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output var ppr_pkg::ppr_word_t prdata,
  output logic pready,
  output logic pslverr,
  // strap and printer pins
  input wire logic enhanced_mode_pin,
  input wire ppr_pkg::ppr_byte_t pd_in,
  output var ppr_pkg::ppr_byte_t pd_out,
  output logic pd_oe,
  input wire logic fault_n,
  input wire logic printer_online_input,
  input wire logic media_out_input,
  input wire logic reply_n,
  input wire logic occupied,
  output logic data_strobe_n,
  output logic auto_feed_n,
  output logic printer_init_n,
  output logic select_out_n,
  output logic port_irq_out,
  output logic port_irq_oe,
  // event interrupt toward the cpu
  output logic irq
);
  import ppr_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  ppr_byte_t data_reg; // output latch, last written byte
  ppr_byte_t ctrl_reg; // port control, bits 7:6 stay zero
  logic flag_n_reg; // active-low port interrupt flag
  logic [`PPR_EVT_W-1:0] evt_reg; // sticky event bits
  logic [`PPR_EVT_W-1:0] mask_reg; // event mask
  ppr_word_t prdata_reg; // read data, loaded in setup phase
  logic [4:0] pins_s; // synchronised printer inputs
  ppr_byte_t pd_s; // synchronised data lines
  logic emode_s; // synchronised enhanced mode strap
  logic fault_n_s; // fault input, active low
  logic online_s; // printer online input
  logic media_s; // media out input
  logic reply_n_s; // reply input, active low
  logic busy_s; // occupied input, active high
  logic reply_prev_reg; // reply level one cycle ago
  logic fault_prev_reg; // fault level one cycle ago
  logic media_prev_reg; // media level one cycle ago
  logic release_ev; // reply went low to high
  logic fault_ev; // fault became active
  logic media_ev; // media out became active
  logic [`PPR_EVT_W-1:0] evt_new; // events of this cycle
  logic [2:0] idx; // word index of the address
  logic mapped; // aligned address of a known register
  logic setup_rd; // read in setup phase
  logic acc; // access phase of any transfer
  logic acc_wr; // access phase of a mapped write
  logic acc_rd; // access phase of a mapped read
  logic dir_in; // data lines turned around to input
  ppr_word_t rd_next; // read data for the addressed register

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // printer handshake and status inputs
  ppr_sync #(.W(5), .RST_VAL(`PPR_IN_RST)) u_sync_pins (
    .clock(clock),
    .rst(rst),
    .pin_in({fault_n, printer_online_input, media_out_input, reply_n,
             ~occupied}),
    .level_out(pins_s)
  );
  // data lines, read back when turned around
  ppr_sync #(.W(8), .RST_VAL(8'h00)) u_sync_data (
    .clock(clock),
    .rst(rst),
    .pin_in(pd_in),
    .level_out(pd_s)
  );
  // strap level, held steady by the board
  ppr_sync #(.W(1), .RST_VAL(1'b0)) u_sync_mode (
    .clock(clock),
    .rst(rst),
    .pin_in(enhanced_mode_pin),
    .level_out(emode_s)
  );

  assign fault_n_s = pins_s[4];
  assign online_s = pins_s[3];
  assign media_s = pins_s[2];
  assign reply_n_s = pins_s[1];
  assign busy_s = ~pins_s[0];

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  assign idx = paddr[4:2];
  assign mapped = (paddr[1:0] == 2'h0) && (idx <= `PPR_IDX_EVT_MASK);
  assign setup_rd = psel && !penable && !pwrite;
  assign acc = psel && penable;
  assign acc_wr = acc && pwrite && mapped;
  assign acc_rd = acc && !pwrite && mapped;
  // no wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = prdata_reg;

  // ---------------------------------------------------------------
  // mode and direction
  // ---------------------------------------------------------------
  // direction bit only counts when the strap selects extended mode
  assign dir_in = emode_s && ctrl_reg[`PPR_CTL_DIR];

  // ---------------------------------------------------------------
  // data latch
  // ---------------------------------------------------------------
  // loaded on every write with pstrb[0] set, in either mode and direction
  always_ff @(posedge clock) begin
    if (rst) begin
      data_reg <= `PPR_DATA_RST;
    end else if (acc_wr && idx == `PPR_IDX_DATA && pstrb[0]) begin
      data_reg <= pwdata[7:0];
    end
  end

  // latch drives the lines unless turned around
  assign pd_out = data_reg;
  assign pd_oe = !dir_in;

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  // reserved bits masked off on write
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_reg <= `PPR_CTL_RST;
    end else if (acc_wr && idx == `PPR_IDX_CONTROL && pstrb[0]) begin
      ctrl_reg <= pwdata[7:0] & `PPR_CTL_WMASK;
    end
  end

  // printer control lines; strobe, feed and select inverted, init_n follows its bit
  assign data_strobe_n = !ctrl_reg[`PPR_CTL_STROBE];
  assign auto_feed_n = !ctrl_reg[`PPR_CTL_AUTOFEED];
  assign printer_init_n = ctrl_reg[`PPR_CTL_INIT];
  assign select_out_n = !ctrl_reg[`PPR_CTL_SELECT];

  // ---------------------------------------------------------------
  // input edge detection
  // ---------------------------------------------------------------
  // previous levels, taken from synchronised inputs only
  always_ff @(posedge clock) begin
    if (rst) begin
      reply_prev_reg <= 1'b1;
      fault_prev_reg <= 1'b1;
      media_prev_reg <= 1'b1;
    end else begin
      reply_prev_reg <= reply_n_s;
      fault_prev_reg <= fault_n_s;
      media_prev_reg <= media_s;
    end
  end

  assign release_ev = reply_n_s && !reply_prev_reg;
  assign fault_ev = !fault_n_s && fault_prev_reg;
  assign media_ev = media_s && !media_prev_reg;

  // ---------------------------------------------------------------
  // port interrupt flag
  // ---------------------------------------------------------------
  // release wins over a status read in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      flag_n_reg <= 1'b1;
    end else if (release_ev) begin
      flag_n_reg <= 1'b0;
    end else if (acc_rd && idx == `PPR_IDX_STATUS) begin
      flag_n_reg <= 1'b1;
    end
  end

  // interrupt pin: driven only while enabled, high while flag pending
  assign port_irq_out = !flag_n_reg;
  assign port_irq_oe = ctrl_reg[`PPR_CTL_IRQ_EN];

  // ---------------------------------------------------------------
  // event status and mask
  // ---------------------------------------------------------------
  always_comb begin
    evt_new = '0;
    evt_new[`PPR_EVT_RELEASE] = release_ev;
    evt_new[`PPR_EVT_FAULT] = fault_ev;
    evt_new[`PPR_EVT_MEDIA] = media_ev;
  end

  // sticky bits; read clears, a new event in that cycle survives
  always_ff @(posedge clock) begin
    if (rst) begin
      evt_reg <= `PPR_EVT_RST;
    end else if (acc_rd && idx == `PPR_IDX_EVT_STATUS) begin
      evt_reg <= evt_new;
    end else begin
      evt_reg <= evt_reg | evt_new;
    end
  end

  // mask register, one bit per event
  always_ff @(posedge clock) begin
    if (rst) begin
      mask_reg <= `PPR_EVT_RST;
    end else if (acc_wr && idx == `PPR_IDX_EVT_MASK && pstrb[0]) begin
      mask_reg <= pwdata[`PPR_EVT_W-1:0];
    end
  end

  // level interrupt toward the cpu
  assign irq = |(evt_reg & mask_reg);

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // selects the addressed register; unmapped reads give zero
  always_comb begin
    rd_next = '0;
    case (idx)
      `PPR_IDX_DATA: begin
        // latch in compatibility or output mode, lines when turned
        rd_next[7:0] = dir_in ? pd_s : data_reg;
      end
      `PPR_IDX_STATUS: begin
        rd_next[1:0] = `PPR_STS_FIXED;
        rd_next[`PPR_STS_FLAG] = flag_n_reg;
        rd_next[6:3] = {reply_n_s, media_s, online_s, fault_n_s};
        rd_next[7] = !busy_s;
      end
      `PPR_IDX_CONTROL: begin
        rd_next[7:0] = ctrl_reg;
      end
      `PPR_IDX_EVT_STATUS: begin
        rd_next[`PPR_EVT_W-1:0] = evt_reg;
      end
      `PPR_IDX_EVT_MASK: begin
        rd_next[`PPR_EVT_W-1:0] = mask_reg;
      end
      default: begin
        rd_next = '0;
      end
    endcase
    if (!mapped) begin
      rd_next = '0;
    end
  end

  // captured in the setup phase, stable through the access phase
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata_reg <= '0;
    end else if (setup_rd) begin
      prdata_reg <= rd_next;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_compat_drive: assert property (!emode_s |-> pd_oe)
    else $error("compatibility mode does not drive data lines");
  a_dir_release: assert property (emode_s && ctrl_reg[5] |-> !pd_oe)
    else $error("data lines driven while turned around");
  a_latch_write: assert property (acc_wr && idx == 3'h0 && pstrb[0]
    |=> data_reg == $past(pwdata[7:0]))
    else $error("data write did not load the latch");
  a_compat_read: assert property (setup_rd && mapped && idx == 3'h0
    && !emode_s |=> prdata[7:0] == $past(data_reg))
    else $error("compatibility data read not the latch");
  a_ext_read: assert property (setup_rd && mapped && idx == 3'h0
    && emode_s && ctrl_reg[5] |=> prdata[7:0] == $past(pd_s))
    else $error("turned around data read not the lines");
  a_status_bits: assert property (setup_rd && mapped && idx == 3'h1
    |=> prdata[1:0] == 2'b11
    && prdata[6:3] == $past({reply_n_s, media_s, online_s, fault_n_s})
    && prdata[7] == !$past(busy_s))
    else $error("status bits wrong");
  a_flag_clear: assert property (release_ev |=> !flag_n_reg)
    else $error("reply release did not clear flag");
  a_flag_set: assert property (acc_rd && idx == 3'h1 && !release_ev
    |=> flag_n_reg)
    else $error("status read did not set flag");
  a_ctrl_back: assert property (acc_wr && idx == 3'h2 && pstrb[0]
    |=> ctrl_reg == ($past(pwdata[7:0]) & 8'h3F)
    ##1 !data_strobe_n == ctrl_reg[0])
    else $error("control readback wrong");
  a_rsvd_zero: assert property (setup_rd && mapped && idx == 3'h2
    |=> prdata[7:6] == 2'b00)
    else $error("reserved control bits not zero");
  a_irq_float: assert property (!ctrl_reg[4] |-> !port_irq_oe)
    else $error("port interrupt driven while disabled");
  a_irq_raise: assert property (release_ev && ctrl_reg[4]
    |=> port_irq_oe && port_irq_out)
    else $error("release did not raise port interrupt");

  c_compat_write: cover property (acc_wr && idx == 3'h0 && !emode_s);
  c_turn_read: cover property (acc_rd && idx == 3'h0 && dir_in);
  c_release_irq: cover property (release_ev && ctrl_reg[4]);
  c_flag_cycle: cover property (!flag_n_reg ##[1:20] acc_rd && idx == 3'h1);
endmodule // ppr_port
`default_nettype wire

// ---- testbench/ppr_printer_model.sv ----
// printer model: data line resolution and acknowledge reply
`timescale 1ns/1ps
`default_nettype none
module ppr_printer_model (
  input wire logic clock,
  input wire logic [7:0] pd_out,
  input wire logic pd_oe,
  input wire logic prn_oe,
  input wire logic [7:0] prn_data,
  input wire logic data_strobe_n,
  input wire logic [3:0] ack_dly,
  output logic [7:0] pd_in,
  output logic reply_n
);
  logic [7:0] last_reg; // line level last seen while driven
  // ------------------------------
  // data line level
  // ------------------------------
  // undriven lines show the inverse of the last driven level
  assign pd_in = pd_oe ? pd_out : prn_oe ? prn_data : ~last_reg;
  always_ff @(posedge clock) begin
    if (pd_oe || prn_oe) begin
      last_reg <= pd_in;
    end
  end
  // ------------------------------
  // acknowledge reply
  // ------------------------------
  // reply after ack_dly cycles; zero means printer stays silent
  initial begin
    reply_n = 1'h1;
    forever begin
      @(negedge data_strobe_n);
      if (ack_dly != 4'h0) begin
        repeat (ack_dly) @(posedge clock);
        reply_n <= 1'h0;
        repeat (2) @(posedge clock);
        reply_n <= 1'h1;
      end
    end
  end
endmodule // ppr_printer_model
`default_nettype wire

// ---- testbench/tb_printer_parallel_port_regs.sv ----
// self-checking bench of the parallel port register block
`timescale 1ns/1ps
`default_nettype none
module tb_printer_parallel_port_regs;
  import ppr_pkg::*;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, pd_oe;
  logic [4:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb, ack_dly;
  ppr_word_t prdata;
  ppr_byte_t pd_in, pd_out, prn_data, d, e;
  logic enhanced_mode_pin, fault_n, printer_online_input, media_out_input;
  logic reply_n, occupied, data_strobe_n, auto_feed_n, printer_init_n;
  logic select_out_n, port_irq_out, port_irq_oe, irq, prn_oe;
  logic [32:0] exp_q[$]; // expected {pslverr, prdata} per read
  int error_cnt, tests_run, cyc;
  // ------------------------------
  // design and printer
  // ------------------------------
  ppr_port uut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .enhanced_mode_pin, .pd_in,
    .pd_out, .pd_oe, .fault_n, .printer_online_input, .media_out_input,
    .reply_n, .occupied, .data_strobe_n, .auto_feed_n, .printer_init_n,
    .select_out_n, .port_irq_out, .port_irq_oe, .irq);
  ppr_printer_model prn (.clock, .pd_out, .pd_oe, .prn_oe, .prn_data,
    .data_strobe_n, .ack_dly, .pd_in, .reply_n);
  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic chk(string n, logic [32:0] ex, logic [32:0] got);
    tests_run++;
    if (got !== ex) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, ex, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // one apb transfer, held until pready at an access edge
  task automatic apb(logic w, logic [4:0] a, logic [7:0] v);
    @(posedge clock);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge clock);
    penable <= 1'h1;
    @(posedge clock);
    while (pready !== 1'h1) @(posedge clock);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(logic [4:0] a, logic [7:0] v);
    apb(1'h1, a, v);
  endtask
  task automatic rd(logic [4:0] a, logic [7:0] v, logic err = 1'h0);
    exp_q.push_back({err, 24'h0, v});
    apb(1'h0, a, 8'h00);
  endtask
  task automatic done(string n);
    $display("test %s done", n);
  endtask
  task automatic wait_pirq();
    for (int i = 0; i < 30 && port_irq_out !== 1'h1; i++) tick(1);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // expected status byte from the pin levels driven now
  function automatic logic [7:0] sts(logic flag);
    return {~occupied, reply_n, media_out_input, printer_online_input,
      fault_n, flag, 2'h3};
  endfunction
  // read monitor compares oldest note; also cuts a hang short
  always @(posedge clock) begin
    if (psel && penable && !pwrite && pready === 1'h1) begin
      if (exp_q.size() > 0) chk("rdata", exp_q.pop_front(), {pslverr, prdata});
    end
    cyc++;
    if (cyc > 5000) begin
      error_cnt++;
      finish_test();
    end
  end
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, enhanced_mode_pin} = '0;
    {fault_n, printer_online_input, media_out_input, occupied} = 4'hC;
    {pstrb, prn_oe, prn_data, ack_dly, rst} = {4'hF, 13'h0, 1'h1};
    {error_cnt, tests_run, cyc} = '0;
    void'($urandom(32'h3073ba55));
    repeat (3) @(posedge clock);
    rst <= 1'h0;
    tick(3);
    rd(5'h00, 8'h00);
    rd(5'h04, sts(1'h1));
    rd(5'h08, 8'h00);
    rd(5'h0C, 8'h00);
    chk("init_n", 1'h0, printer_init_n);
    chk("pirq_oe", 1'h0, port_irq_oe);
    done("reset");
    d = 8'($urandom);
    wr(5'h00, d);
    prn_oe <= 1'h1;
    prn_data <= ~d;
    tick(1);
    chk("pd_out", d, pd_out);
    wr(5'h08, 8'h20);
    tick(1);
    chk("pd_oe", 1'h1, pd_oe);
    rd(5'h00, d);
    done("compat");
    enhanced_mode_pin <= 1'h1;
    wr(5'h08, 8'h00);
    tick(3);
    chk("pd_oe", 1'h1, pd_oe);
    rd(5'h00, d);
    e = 8'($urandom);
    prn_data <= e;
    wr(5'h08, 8'h20);
    tick(3);
    chk("pd_oe", 1'h0, pd_oe);
    rd(5'h00, e);
    d = 8'($urandom);
    wr(5'h00, d);
    tick(1);
    chk("pd_oe", 1'h0, pd_oe);
    rd(5'h00, e);
    prn_oe <= 1'h0;
    wr(5'h08, 8'h00);
    tick(1);
    chk("pd_out", d, pd_out);
    rd(5'h00, d);
    pstrb <= 4'hE;
    wr(5'h00, ~d);
    pstrb <= 4'hF;
    rd(5'h00, d);
    done("extended");
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'hFF : 8'($urandom);
      wr(5'h08, d);
      tick(1);
      rd(5'h08, d & 8'h3F);
      chk("strobe_n", !d[0], data_strobe_n);
      chk("feed_n", !d[1], auto_feed_n);
      chk("init_n", d[2], printer_init_n);
      chk("sel_n", !d[3], select_out_n);
      chk("pirq_oe", d[4], port_irq_oe);
      chk("pd_oe", !d[5], pd_oe);
    end
    done("control");
    wr(5'h10, 8'h01);
    ack_dly <= 4'h1;
    wr(5'h08, 8'h14);
    wr(5'h08, 8'h15);
    wait_pirq();
    chk("pirq", 1'h1, port_irq_out);
    chk("pirq_oe", 1'h1, port_irq_oe);
    chk("irq", 1'h1, irq);
    rd(5'h04, sts(1'h0));
    tick(1);
    chk("pirq", 1'h0, port_irq_out);
    rd(5'h04, sts(1'h1));
    rd(5'h0C, 8'h01);
    tick(1);
    chk("irq", 1'h0, irq);
    done("irq_fast");
    wr(5'h10, 8'h00);
    ack_dly <= 4'h6;
    wr(5'h08, 8'h04);
    wr(5'h08, 8'h05);
    wait_pirq();
    chk("pirq", 1'h1, port_irq_out);
    chk("pirq_oe", 1'h0, port_irq_oe);
    chk("irq", 1'h0, irq);
    rd(5'h0C, 8'h01);
    rd(5'h04, sts(1'h0));
    done("irq_slow");
    ack_dly <= 4'h0;
    wr(5'h10, 8'h04);
    {fault_n, media_out_input} <= 2'h1;
    tick(4);
    chk("irq", 1'h1, irq);
    rd(5'h0C, 8'h06);
    tick(1);
    chk("irq", 1'h0, irq);
    for (int i = 0; i < 6; i++) begin
      {fault_n, printer_online_input, media_out_input, occupied} <= 4'($urandom);
      tick(4);
      rd(5'h04, sts(1'h1));
    end
    wr(5'h04, 8'h00);
    rd(5'h04, sts(1'h1));
    rd(5'h14, 8'h00, 1'h1);
    rd(5'h01, 8'h00, 1'h1);
    done("status");
    finish_test();
  end
endmodule // tb_printer_parallel_port_regs
`default_nettype wire
